// ---- hw/clkgen_pkg.sv ----
// Purpose: shared constants, types and decoders of the peripheral clock generator
// Assumes: all clock sources arrive as one-cycle tick strobes synchronous to clk
// Notes:   a derived clock toggles after (divider code + 1) ticks of its source
package clkgen_pkg;

    // source tick vector and selector layout
    localparam int NUM_SRC   = 8;
    localparam int SEL_W     = 4;
    localparam int SRC_IDX_W = 3;
    localparam int DIV_W     = 4;
    localparam int SYS_SEL_W = 3;
    localparam int KDIV_W    = 3;

    // positions of the sources in the tick vector
    localparam int SRC_OSC     = 0;
    localparam int SRC_PLL_A_P = 1;
    localparam int SRC_PLL_A_Q = 2;
    localparam int SRC_PLL_A_R = 3;
    localparam int SRC_PLL_B_P = 4;
    localparam int SRC_PLL_B_Q = 5;
    localparam int SRC_PLL_B_R = 6;
    localparam int SRC_EXT_OSC = 7;

    // derived clock slots
    localparam int NUM_KCLK  = 5;
    localparam int KC_BUS    = 0;
    localparam int KC_SERIAL = 1;
    localparam int KC_SPI    = 2;
    localparam int KC_OCTAL  = 3;
    localparam int KC_CANFD  = 4;

    // pin function select
    localparam int              PSEL_W       = 5;
    localparam logic [PSEL_W-1:0] PSEL_CLK_OUT = 5'h0b;

    // divider state after reset
    localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
    localparam logic [DIV_W-1:0] DIV_RST = 4'h0;
    localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;

    // boot option word and oscillator frequency code
    localparam int                    BOOT_W        = 32;
    localparam int                    BOOT_FREQ_LSB = 0;
    localparam int                    OSC_CODE_W    = 3;
    localparam int                    MHZ_W         = 6;
    localparam logic [OSC_CODE_W-1:0] OSC_16M       = 3'h0;
    localparam logic [OSC_CODE_W-1:0] OSC_18M       = 3'h1;
    localparam logic [OSC_CODE_W-1:0] OSC_20M       = 3'h2;
    localparam logic [OSC_CODE_W-1:0] OSC_32M       = 3'h4;
    localparam logic [OSC_CODE_W-1:0] OSC_48M       = 3'h7;
    localparam logic [OSC_CODE_W-1:0] LIVE_OSC_RST  = 3'h0;

    // pll configuration word
    typedef struct packed {
        logic [7:0] multiplier;
        logic [1:0] fraction;
        logic [1:0] input_divider;
        logic [3:0] out_div_p;
        logic [3:0] out_div_q;
        logic [3:0] out_div_r;
    } pll_cfg_t;

    localparam pll_cfg_t PLL_CFG_RST = '0;

    // true for the frequency codes that may be applied
    function automatic logic osc_code_legal(input logic [OSC_CODE_W-1:0] code);
        return (code == OSC_16M) || (code == OSC_18M) || (code == OSC_20M) ||
               (code == OSC_32M) || (code == OSC_48M);
    endfunction

    // frequency in MHz for a code, zero for prohibited codes
    function automatic logic [MHZ_W-1:0] osc_code_mhz(input logic [OSC_CODE_W-1:0] code);
        logic [MHZ_W-1:0] mhz;
        mhz = 6'h00;
        unique case (code)
            OSC_16M: mhz = 6'h10;
            OSC_18M: mhz = 6'h12;
            OSC_20M: mhz = 6'h14;
            OSC_32M: mhz = 6'h20;
            OSC_48M: mhz = 6'h30;
            default: mhz = 6'h00;
        endcase
        return mhz;
    endfunction

endpackage

// ---- hw/kclk_if.sv ----
// Purpose: carrier between the generator top and one divider slice
// Assumes: single clk domain
// Notes:   rise and fall are one-cycle pulses aligned with the new clk_out level
`timescale 1ns/100ps
`default_nettype none
interface kclk_if;
    import clkgen_pkg::*;
    logic [NUM_SRC-1:0] src_tick;
    logic [SEL_W-1:0]   sel;
    logic [DIV_W-1:0]   div;
    logic               clk_out;
    logic               rise;
    logic               fall;

    modport ctrl (output src_tick, output sel, output div,
                  input clk_out, input rise, input fall);
    modport gen  (input src_tick, input sel, input div,
                  output clk_out, output rise, output fall);
endinterface
`default_nettype wire

// ---- hw/kernel_clock_div.sv ----
// Purpose: source select and divider for one derived clock
// Assumes: sel[3] set means no source, the clock then parks low
// Notes:   new settings are taken only at the start of a low phase
`timescale 1ns/100ps
`default_nettype none
module kernel_clock_div (
    input  wire logic clk,
    input  wire logic rst_n,
    kclk_if.gen       kif
);
    import clkgen_pkg::*;

    logic [SEL_W-1:0] cur_sel_reg;
    logic [DIV_W-1:0] cur_div_reg;
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic             clk_reg;
    logic             rise_reg;
    logic             fall_reg;

    // selected tick, terminal count and safe load point
    wire src_ok = ~cur_sel_reg[SEL_W-1];
    wire tick   = src_ok & kif.src_tick[cur_sel_reg[SRC_IDX_W-1:0]];
    wire term   = tick & (cnt_reg == cur_div_reg);
    wire load   = ~clk_reg & (cnt_reg == '0);
    assign cnt_next = term ? '0 : (tick ? cnt_reg + DIV_ONE : cnt_reg);

    // settings only change while the output is low and a phase has just begun
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_sel_reg <= SEL_RST;
            cur_div_reg <= DIV_RST;
        end else if (load) begin
            cur_sel_reg <= kif.sel;
            cur_div_reg <= kif.div;
        end
    end

    // half period of (div + 1) source ticks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            clk_reg  <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            clk_reg  <= clk_reg ^ term;
            rise_reg <= term & ~clk_reg;
            fall_reg <= term & clk_reg;
        end
    end

    assign kif.clk_out = clk_reg;
    assign kif.rise    = rise_reg;
    assign kif.fall    = fall_reg;

    // output toggles exactly at terminal count and never otherwise
    a_div_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        term |=> (clk_reg != $past(clk_reg)))
        else $error("divider did not toggle at terminal count");

    a_div_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !term |=> $stable(clk_reg))
        else $error("divider toggled without terminal count");

    // settings switch only at the start of a low phase
    a_switch_low_phase: assert property (@(posedge clk) disable iff (!rst_n)
        ($changed(cur_sel_reg) || $changed(cur_div_reg)) |-> $past(!clk_reg) && $past(cnt_reg == '0))
        else $error("divider settings changed outside a clean boundary");

endmodule // kernel_clock_div
`default_nettype wire

// ---- hw/peripheral_clock_gen.sv ----
// Purpose: derives bus, sdram and kernel clocks, gates clock pins, holds osc code
// Assumes: all inputs synchronous to clk; sources are tick strobes
// Notes:   clocks are produced as registered levels in the clk domain
// Contract
// - bus pin driven when enabled and function matches
// - halving bit outputs bus clock divided two
// - bus and sdram clocks feed bus controller
// - sdram pin driven when enabled and function matches
// - bus clock from divider on system source
// - first pll configured by its field set
// - second pll has same field widths
// - serial kernel clock own divider and source
// - spi kernel clock own divider and source
// - octal kernel clock own divider and source
// - canfd kernel clock own divider and source
// - boot selector picks secure or nonsecure word
// - boot frequency code loaded after reset release
// - frequency codes map to five legal values
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_gen (
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    // clock source ticks
    input  wire logic                                osc_tick,
    input  wire logic                                ext_osc_tick,
    input  wire logic                                pll_a_p_tick,
    input  wire logic                                pll_a_q_tick,
    input  wire logic                                pll_a_r_tick,
    input  wire logic                                pll_b_p_tick,
    input  wire logic                                pll_b_q_tick,
    input  wire logic                                pll_b_r_tick,
    // dividers and source selects
    input  wire logic [clkgen_pkg::SYS_SEL_W-1:0]    system_source_select,
    input  wire logic [clkgen_pkg::DIV_W-1:0]        bus_clock_divider,
    input  wire logic [clkgen_pkg::SEL_W-1:0]        serial_kernel_source,
    input  wire logic [clkgen_pkg::KDIV_W-1:0]       serial_kernel_divider,
    input  wire logic [clkgen_pkg::SEL_W-1:0]        spi_kernel_source,
    input  wire logic [clkgen_pkg::KDIV_W-1:0]       spi_kernel_divider,
    input  wire logic [clkgen_pkg::SEL_W-1:0]        octal_kernel_source,
    input  wire logic [clkgen_pkg::KDIV_W-1:0]       octal_kernel_divider,
    input  wire logic [clkgen_pkg::SEL_W-1:0]        canfd_kernel_source,
    input  wire logic [clkgen_pkg::KDIV_W-1:0]       canfd_kernel_divider,
    // pll configuration
    input  wire clkgen_pkg::pll_cfg_t                pll_a_cfg_in,
    input  wire clkgen_pkg::pll_cfg_t                pll_b_cfg_in,
    output clkgen_pkg::pll_cfg_t                     pll_a_cfg,
    output clkgen_pkg::pll_cfg_t                     pll_b_cfg,
    // pin control
    input  wire logic                                bus_clock_out_enable,
    input  wire logic                                bus_clock_halve,
    input  wire logic [clkgen_pkg::PSEL_W-1:0]       bus_pin_function,
    input  wire logic                                sdram_clock_out_enable,
    input  wire logic [clkgen_pkg::PSEL_W-1:0]       sdram_pin_function,
    input  wire logic                                bus_clock_pin_in,
    input  wire logic                                sdram_clock_pin_in,
    output logic                                     bus_clock_pin,
    output logic                                     bus_clock_pin_oe_n,
    output logic                                     sdram_clock_pin,
    output logic                                     sdram_clock_pin_oe_n,
    // derived clocks
    output logic                                     ctrl_bus_clock,
    output logic                                     ctrl_sdram_clock,
    output logic                                     serial_kernel_clock,
    output logic                                     spi_kernel_clock,
    output logic                                     octal_kernel_clock,
    output logic                                     canfd_kernel_clock,
    // oscillator frequency code
    input  wire logic [clkgen_pkg::BOOT_W-1:0]       boot_option_word_nonsecure,
    input  wire logic [clkgen_pkg::BOOT_W-1:0]       boot_option_word_secure,
    input  wire logic                                boot_option_selector,
    input  wire logic                                osc_stop_bit,
    input  wire logic                                live_osc_wr,
    input  wire logic [clkgen_pkg::OSC_CODE_W-1:0]   live_osc_wdata,
    output logic [clkgen_pkg::OSC_CODE_W-1:0]        live_osc_freq_code,
    output logic [clkgen_pkg::MHZ_W-1:0]             osc_freq_mhz,
    output logic                                     live_osc_wr_refused
);
    import clkgen_pkg::*;

    kclk_if kif [NUM_KCLK] ();

    logic [NUM_SRC-1:0]    src_ticks;
    logic [SEL_W-1:0]      sel_vec [NUM_KCLK];
    logic [DIV_W-1:0]      div_vec [NUM_KCLK];
    logic [NUM_KCLK-1:0]   kclk_vec;
    logic                  bus_rise;

    logic                  halve_reg;
    logic                  halve_eff_reg;
    logic                  bus_en_eff_reg;
    logic                  sd_en_eff_reg;
    logic                  bus_pin_reg;
    logic                  bus_oe_n_reg;
    logic                  sd_pin_reg;
    logic                  sd_oe_n_reg;
    logic                  ctrl_bus_reg;
    logic                  ctrl_sd_reg;
    pll_cfg_t              pll_a_reg;
    pll_cfg_t              pll_b_reg;
    logic [OSC_CODE_W-1:0] osc_code_reg;
    logic [MHZ_W-1:0]      osc_mhz_reg;
    logic                  boot_load_reg;
    logic                  wr_refused_reg;

    // source tick vector in the order of the selector codes
    assign src_ticks = {ext_osc_tick, pll_b_r_tick, pll_b_q_tick, pll_b_p_tick,
                        pll_a_r_tick, pll_a_q_tick, pll_a_p_tick, osc_tick};

    // settings per slice, narrow fields widened with zeros
    assign sel_vec[KC_BUS]    = {1'b0, system_source_select};
    assign div_vec[KC_BUS]    = bus_clock_divider;
    assign sel_vec[KC_SERIAL] = serial_kernel_source;
    assign div_vec[KC_SERIAL] = {1'b0, serial_kernel_divider};
    assign sel_vec[KC_SPI]    = spi_kernel_source;
    assign div_vec[KC_SPI]    = {1'b0, spi_kernel_divider};
    assign sel_vec[KC_OCTAL]  = octal_kernel_source;
    assign div_vec[KC_OCTAL]  = {1'b0, octal_kernel_divider};
    assign sel_vec[KC_CANFD]  = canfd_kernel_source;
    assign div_vec[KC_CANFD]  = {1'b0, canfd_kernel_divider};

    // one independent divider slice per derived clock
    for (genvar g = 0; g < NUM_KCLK; g++) begin : g_slice
        assign kif[g].src_tick = src_ticks;
        assign kif[g].sel      = sel_vec[g];
        assign kif[g].div      = div_vec[g];
        assign kclk_vec[g]     = kif[g].clk_out;
        kernel_clock_div u_div (
            .clk   (clk),
            .rst_n (rst_n),
            .kif   (kif[g])
        );
    end

    assign bus_rise            = kif[KC_BUS].rise;
    assign serial_kernel_clock = kclk_vec[KC_SERIAL];
    assign spi_kernel_clock    = kclk_vec[KC_SPI];
    assign octal_kernel_clock  = kclk_vec[KC_OCTAL];
    assign canfd_kernel_clock  = kclk_vec[KC_CANFD];

    // pin source selection and function decode
    wire bus_clk    = kclk_vec[KC_BUS];
    wire bus_src    = halve_eff_reg ? halve_reg : bus_clk;
    wire bus_func   = (bus_pin_function == PSEL_CLK_OUT);
    wire sd_func    = (sdram_pin_function == PSEL_CLK_OUT);
    wire both_low   = ~bus_clk & ~halve_reg;

    // halved bus clock, toggling on every rising edge of the bus clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halve_reg     <= 1'b0;
            halve_eff_reg <= 1'b0;
        end else begin
            halve_reg     <= halve_reg ^ bus_rise;
            halve_eff_reg <= both_low ? bus_clock_halve : halve_eff_reg;
        end
    end

    // enables take effect only while the pin source is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_en_eff_reg <= 1'b0;
            sd_en_eff_reg  <= 1'b0;
        end else begin
            bus_en_eff_reg <= bus_src ? bus_en_eff_reg : bus_clock_out_enable;
            sd_en_eff_reg  <= bus_clk ? sd_en_eff_reg : sdram_clock_out_enable;
        end
    end

    // pins: driven while the function matches, clock only when enabled
    // a function change while enabled may cut a pulse, software avoids it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_pin_reg  <= 1'b0;
            bus_oe_n_reg <= 1'b1;
            sd_pin_reg   <= 1'b0;
            sd_oe_n_reg  <= 1'b1;
        end else begin
            bus_pin_reg  <= bus_src & bus_en_eff_reg & bus_func;
            bus_oe_n_reg <= ~bus_func;
            sd_pin_reg   <= bus_clk & sd_en_eff_reg & sd_func;
            sd_oe_n_reg  <= ~sd_func;
        end
    end

    // operating clocks of the external bus controller
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_bus_reg <= 1'b0;
            ctrl_sd_reg  <= 1'b0;
        end else begin
            ctrl_bus_reg <= bus_clk;
            ctrl_sd_reg  <= bus_clk;
        end
    end

    assign bus_clock_pin        = bus_pin_reg;
    assign bus_clock_pin_oe_n   = bus_oe_n_reg;
    assign sdram_clock_pin      = sd_pin_reg;
    assign sdram_clock_pin_oe_n = sd_oe_n_reg;
    assign ctrl_bus_clock       = ctrl_bus_reg;
    assign ctrl_sdram_clock     = ctrl_sd_reg;

    // pll settings registered toward the analog macros
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_a_reg <= PLL_CFG_RST;
            pll_b_reg <= PLL_CFG_RST;
        end else begin
            pll_a_reg <= pll_a_cfg_in;
            pll_b_reg <= pll_b_cfg_in;
        end
    end

    assign pll_a_cfg = pll_a_reg;
    assign pll_b_cfg = pll_b_reg;

    // applied boot word and the software write decode
    wire [BOOT_W-1:0]     boot_word = boot_option_selector ? boot_option_word_secure
                                                           : boot_option_word_nonsecure;
    wire [OSC_CODE_W-1:0] boot_code = boot_word[BOOT_FREQ_LSB +: OSC_CODE_W];
    wire                  wr_ok     = live_osc_wr & ~boot_load_reg & osc_stop_bit &
                                      osc_code_legal(live_osc_wdata);
    wire [OSC_CODE_W-1:0] osc_code_next = boot_load_reg ? boot_code :
                                          (wr_ok ? live_osc_wdata : osc_code_reg);

    // live frequency code: boot value on the first edge after release, then software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_load_reg  <= 1'b1;
            osc_code_reg   <= LIVE_OSC_RST;
            osc_mhz_reg    <= '0;
            wr_refused_reg <= 1'b0;
        end else begin
            boot_load_reg  <= 1'b0;
            osc_code_reg   <= osc_code_next;
            osc_mhz_reg    <= osc_code_mhz(osc_code_next);
            wr_refused_reg <= live_osc_wr & ~wr_ok;
        end
    end

    assign live_osc_freq_code  = osc_code_reg;
    assign osc_freq_mhz        = osc_mhz_reg;
    assign live_osc_wr_refused = wr_refused_reg;

    // bus pin only clocks with the clock function selected
    a_bus_pin_func: assert property (@(posedge clk) disable iff (!rst_n)
        bus_pin_reg |-> $past(bus_func) && $past(bus_en_eff_reg) && !bus_oe_n_reg)
        else $error("bus clock pin high without function or enable");

    // halved mode follows the halving flop one cycle later
    a_halve_follow: assert property (@(posedge clk) disable iff (!rst_n)
        (halve_eff_reg && bus_en_eff_reg && bus_func) |=> (bus_pin_reg == $past(halve_reg)))
        else $error("bus clock pin not showing halved clock");

    a_halve_rate: assert property (@(posedge clk) disable iff (!rst_n)
        bus_rise |=> (halve_reg != $past(halve_reg)))
        else $error("halved clock missed a bus clock rising edge");

    a_ctrl_clock_pair: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (ctrl_bus_reg == $past(bus_clk)) && (ctrl_sd_reg == ctrl_bus_reg))
        else $error("controller clocks not following the bus clock");

    a_sdram_pin_func: assert property (@(posedge clk) disable iff (!rst_n)
        sd_pin_reg |-> $past(sd_func) && $past(sd_en_eff_reg) && !sd_oe_n_reg)
        else $error("sdram clock pin high without function or enable");

    a_pll_cfg_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (pll_a_reg == $past(pll_a_cfg_in)) && (pll_b_reg == $past(pll_b_cfg_in)))
        else $error("pll configuration not applied");

    a_boot_load: assert property (@(posedge clk) disable iff (!rst_n)
        (boot_load_reg && rst_n) |=> (osc_code_reg == $past(boot_code)) && !boot_load_reg)
        else $error("boot frequency code not loaded after reset");

    a_write_guard: assert property (@(posedge clk) disable iff (!rst_n)
        (!boot_load_reg && !osc_stop_bit) |=> $stable(osc_code_reg))
        else $error("frequency code changed while oscillator runs");

    a_mhz_decode: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n |=> (osc_mhz_reg == osc_code_mhz(osc_code_reg)))
        else $error("frequency value does not match code");

    a_pin_low_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        (!bus_en_eff_reg && !sd_en_eff_reg) |=> !bus_pin_reg && !sd_pin_reg)
        else $error("clock pin active while disabled");

endmodule // peripheral_clock_gen
`default_nettype wire

// ---- dv/clk_sink.sv ----
// Purpose: far side model, devices taking the pin clocks
// Assumes: pins sampled on clk
// Notes:   counts bus pin rises, echoes pins to pad inputs
`timescale 1ns/100ps
`default_nettype none
module clk_sink (
    input  wire logic clk,
    input  wire logic bus_pin,
    input  wire logic sd_pin,
    output logic      bus_back,
    output logic      sd_back,
    output int        bus_rises
);
    logic last_reg;
    // pad inputs read back what the pins carry
    assign bus_back = bus_pin;
    assign sd_back = sd_pin;
    // count rising edges seen on the bus clock pin
    initial bus_rises = 0;
    always @(posedge clk) begin
        last_reg <= bus_pin;
        if (bus_pin && !last_reg) bus_rises <= bus_rises + 1;
    end
endmodule // clk_sink
`default_nettype wire

// ---- dv/peripheral_clock_gen_test.sv ----
// Purpose: self-checking bench of the clock generator
// Assumes: one tick per cycle, periods count clk cycles
// Notes:   expectations come from the codes set here
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_gen_test;
    import clkgen_pkg::*;
    logic clk, rst_n, osc_tick, ext_osc_tick, pll_a_p_tick, pll_a_q_tick, pll_a_r_tick;
    logic pll_b_p_tick, pll_b_q_tick, pll_b_r_tick, bus_clock_out_enable, bus_clock_halve;
    logic sdram_clock_out_enable, bus_clock_pin_in, sdram_clock_pin_in, boot_option_selector;
    logic osc_stop_bit, live_osc_wr, bus_clock_pin, bus_clock_pin_oe_n, sdram_clock_pin;
    logic sdram_clock_pin_oe_n, ctrl_bus_clock, ctrl_sdram_clock, serial_kernel_clock;
    logic spi_kernel_clock, octal_kernel_clock, canfd_kernel_clock, live_osc_wr_refused;
    logic [2:0] system_source_select, live_osc_wdata, live_osc_freq_code, dv [4];
    logic [2:0] serial_kernel_divider, spi_kernel_divider, octal_kernel_divider;
    logic [2:0] canfd_kernel_divider;
    logic [3:0] bus_clock_divider, serial_kernel_source, spi_kernel_source;
    logic [3:0] octal_kernel_source, canfd_kernel_source;
    logic [4:0] bus_pin_function, sdram_pin_function;
    logic [5:0] osc_freq_mhz;
    logic [31:0] boot_option_word_nonsecure, boot_option_word_secure;
    pll_cfg_t pll_a_cfg_in, pll_b_cfg_in, pll_a_cfg, pll_b_cfg;
    logic [7:0] tk;
    int miscompares, samples_checked, bus_rises, b, h, r;
    int oc [5] = '{0, 1, 2, 4, 7};
    int om [5] = '{16, 18, 20, 32, 48};
    wire [6:0] ck = {sdram_clock_pin, canfd_kernel_clock, octal_kernel_clock,
        spi_kernel_clock, serial_kernel_clock, ctrl_bus_clock, bus_clock_pin};
    assign {ext_osc_tick, pll_b_r_tick, pll_b_q_tick, pll_b_p_tick, pll_a_r_tick,
        pll_a_q_tick, pll_a_p_tick, osc_tick} = tk;
    peripheral_clock_gen dut (.*);
    clk_sink sink (.clk, .bus_pin(bus_clock_pin), .sd_pin(sdram_clock_pin),
        .bus_back(bus_clock_pin_in), .sd_back(sdram_clock_pin_in), .bus_rises);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            miscompares++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask
    // cycles between two rises of derived clock i
    task automatic per(input int i, input int e);
        int n;
        int k;
        logic p;
        n = 0;
        k = 0;
        p = 1'b1;
        while (k < 2 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
            if (ck[i] === 1'b1 && p === 1'b0) k++;
            if (ck[i] === 1'b1 && p === 1'b0 && k == 1) n = 0;
            p = ck[i];
        end
        chk("period", e, n);
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk);
        rst_n <= 1'b0;
        boot_option_selector <= s;
        boot_option_word_nonsecure <= $urandom;
        boot_option_word_secure <= $urandom;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        r = s ? boot_option_word_secure[2:0] : boot_option_word_nonsecure[2:0];
        chk("boot", r, live_osc_freq_code);
        h = 0;
        foreach (oc[j]) if (oc[j] == r) h = om[j];
        chk("boot mhz", h, osc_freq_mhz);
    endtask
    task automatic wr(input logic stop, input logic [2:0] d, input logic ok);
        logic [2:0] old;
        old = live_osc_freq_code;
        @(posedge clk);
        osc_stop_bit <= stop;
        live_osc_wr <= 1'b1;
        live_osc_wdata <= d;
        @(posedge clk);
        live_osc_wr <= 1'b0;
        #1;
        chk("osc", ok ? d : old, live_osc_freq_code);
        chk("refused", !ok, live_osc_wr_refused);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        final_report();
    end
    initial begin
        void'($urandom(32));
        rst_n = 1'b0;
        {bus_clock_out_enable, bus_clock_halve, sdram_clock_out_enable, osc_stop_bit} = '0;
        {live_osc_wr, boot_option_selector, live_osc_wdata, system_source_select} = '0;
        {serial_kernel_source, spi_kernel_source, octal_kernel_source, canfd_kernel_source,
            serial_kernel_divider, spi_kernel_divider, octal_kernel_divider,
            canfd_kernel_divider, bus_clock_divider, tk} = '0;
        {bus_pin_function, sdram_pin_function, pll_a_cfg_in, pll_b_cfg_in} = '0;
        {boot_option_word_nonsecure, boot_option_word_secure} = '0;
        do_reset(1'b0);
        do_reset(1'b1);
        wr(1'b0, 3'h4, 1'b0);
        wr(1'b1, 3'h3, 1'b0);
        foreach (oc[j]) begin
            wr(1'b1, 3'(oc[j]), 1'b1);
            chk("mhz", om[j], osc_freq_mhz);
        end
        repeat (4) begin
            @(posedge clk);
            pll_a_cfg_in <= $urandom;
            pll_b_cfg_in <= $urandom;
            @(posedge clk);
            #1;
            chk("pll a", pll_a_cfg_in, pll_a_cfg);
            chk("pll b", pll_b_cfg_in, pll_b_cfg);
        end
        // function set while the outputs are still disabled
        bus_pin_function <= PSEL_CLK_OUT;
        sdram_pin_function <= PSEL_CLK_OUT;
        @(posedge clk);
        bus_clock_out_enable <= 1'b1;
        sdram_clock_out_enable <= 1'b1;
        // every source feeds every clock; old tick kept until the switch lands
        for (int s = 0; s < 8; s++) begin
            foreach (dv[j]) dv[j] = 3'($urandom_range(7));
            b = $urandom_range(15);
            h = $urandom_range(1);
            @(posedge clk);
            tk <= tk | (8'h01 << s);
            system_source_select <= 3'(s);
            bus_clock_divider <= 4'(b);
            bus_clock_halve <= h[0];
            {serial_kernel_source, spi_kernel_source, octal_kernel_source,
                canfd_kernel_source} <= {4{4'(s)}};
            {serial_kernel_divider, spi_kernel_divider, octal_kernel_divider,
                canfd_kernel_divider} <= {dv[0], dv[1], dv[2], dv[3]};
            repeat (80) @(posedge clk);
            tk <= 8'h01 << s;
            per(0, 2 * (b + 1) * (h + 1));
            per(6, 2 * (b + 1));
            per(1, 2 * (b + 1));
            chk("sdram ctrl", ctrl_bus_clock, ctrl_sdram_clock);
            for (int j = 0; j < 4; j++) per(j + 2, 2 * (dv[j] + 1));
        end
        chk("oe_n", 2'b00, {bus_clock_pin_oe_n, sdram_clock_pin_oe_n});
        @(posedge clk);
        bus_clock_out_enable <= 1'b0;
        sdram_clock_out_enable <= 1'b0;
        serial_kernel_source <= 4'h8;
        repeat (80) @(posedge clk);
        r = bus_rises;
        sdram_pin_function <= 5'h0a;
        repeat (80) @(posedge clk);
        #1;
        chk("rises", r, bus_rises);
        chk("parked", 3'b000, {bus_clock_pin, sdram_clock_pin, serial_kernel_clock});
        chk("sd oe_n", 1'b1, sdram_clock_pin_oe_n);
        final_report();
    end
endmodule // peripheral_clock_gen_test
`default_nettype wire
